/* File: pbs_sequencer.sv */
/*
 * pbs_sequencer: push-button on/off sequencer with host kill handshake,
 * shutdown interrupt, forced power-off, supply lockout and supervisor.
 * assumes all inputs are synchronous to sys_clk_in; comparators are external
 * and deliver logic levels. the host drives power_kill_n_in.
 */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - power on after full 32 ms press
// - kill input ignored for 512 ms blanking
// - kill still low at blank end aborts
// - only the push button turns power on
// - 32 ms low on input raises interrupt
// - kill low after blanking drops power
// - first low input owns power-down sequence
// - long hold forces power off
// - fail warning follows comparator with hysteresis
// - low supply locks out button turn-on
// - supervisor reset held 200 ms after good
// - interrupt min 32 ms, held while pressed, cleared at power-off
// - forced off releases interrupt and enable together
// - enable polarity selectable
// - no capacitor uses 64 ms default hold
module pbs_sequencer
	import pbs_pkg::*;
#(
	parameter logic             EN_ACTIVE_HIGH = EN_HIGH_DEF,
	parameter int unsigned      ON_DB_P        = ON_DB_CYC,
	parameter int unsigned      OFF_DB_P       = OFF_DB_CYC,
	parameter int unsigned      INT_MIN_P      = INT_MIN_CYC,
	parameter int unsigned      BLANK_P        = BLANK_CYC,
	parameter int unsigned      PD_MIN_P       = PD_MIN_CYC,
	parameter int unsigned      PDT_DEF_P      = PDT_DEF_CYC
) (
	input  wire logic             sys_clk_in,
	input  wire logic             reset_n_in,
	input  wire logic             push_button_n_in,
	input  wire logic             supply_low_in,
	input  wire logic             power_kill_n_in,
	input  wire logic             hold_delay_cap_in,
	input  wire logic [CNT_W-1:0] extra_hold_cyc_in,
	input  wire logic             fail_below_in,
	input  wire logic             fail_above_in,
	input  wire logic             monitored_supply_low_in,
	output logic                  power_enable_out,
	output logic                  interrupt_n_out,
	output logic                  fail_warn_n_out,
	output logic                  supervisor_reset_n_out
);
	pbs_state_t       state_r, state_nxt;
	pbs_src_t         src_r, src_nxt;
	logic [CNT_W-1:0] blank_r, blank_nxt;
	logic [CNT_W-1:0] int_cnt_r, int_cnt_nxt;
	logic             int_on_r, int_on_nxt;
	logic             need_rel_r, need_rel_nxt;
	logic             en_out_nxt;
	logic             int_out_nxt;
	logic [CNT_W-1:0] btn_cnt;
	logic [CNT_W-1:0] sup_cnt;
	logic [CNT_W-1:0] own_cnt;
	logic [CNT_W-1:0] hold_lim;
	logic             own_low;
	logic             force_off;
	logic             powered;
	pbs_req_t         req;

	assign req.btn_low = !push_button_n_in;
	assign req.sup_low = supply_low_in;

	// restarting low-time counters, one per power-down input
	pbs_low_timer u_btn_timer (
		.sys_clk_in (sys_clk_in),
		.reset_n_in (reset_n_in),
		.active_in  (req.btn_low),
		.count_out  (btn_cnt)
	);
	pbs_low_timer u_sup_timer (
		.sys_clk_in (sys_clk_in),
		.reset_n_in (reset_n_in),
		.active_in  (req.sup_low),
		.count_out  (sup_cnt)
	);

	pbs_supervisor u_supervisor (
		.sys_clk_in             (sys_clk_in),
		.reset_n_in             (reset_n_in),
		.supply_below_in        (monitored_supply_low_in),
		.fail_below_in          (fail_below_in),
		.fail_above_in          (fail_above_in),
		.supervisor_reset_n_out (supervisor_reset_n_out),
		.fail_warn_n_out        (fail_warn_n_out)
	);

	// extra hold taken from the capacitor input, else the fixed default
	assign hold_lim  = CNT_W'(PD_MIN_P) + (hold_delay_cap_in ? extra_hold_cyc_in : CNT_W'(PDT_DEF_P));
	assign own_cnt   = (src_r == PBS_SRC_BTN) ? btn_cnt : sup_cnt;
	assign own_low   = (src_r == PBS_SRC_BTN) ? req.btn_low : (src_r == PBS_SRC_SUP) && req.sup_low;
	assign force_off = own_low && (own_cnt >= hold_lim - 1'b1);
	assign powered   = (state_r != PBS_OFF);

	always_comb begin
		state_nxt    = state_r;
		src_nxt      = src_r;
		blank_nxt    = blank_r;
		int_cnt_nxt  = int_cnt_r;
		int_on_nxt   = int_on_r;
		need_rel_nxt = need_rel_r;
		if (!req.btn_low) begin
			need_rel_nxt = 1'b0;
		end
		unique case (state_r)
			PBS_OFF: begin
				src_nxt    = PBS_SRC_NONE;
				int_on_nxt = 1'b0;
				// button only; lockout while supply low; fresh press after release
				if (!need_rel_r && !req.sup_low && req.btn_low && btn_cnt >= CNT_W'(ON_DB_P - 1)) begin
					state_nxt    = PBS_BLANK;
					blank_nxt    = '0;
					need_rel_nxt = 1'b1;
				end
			end
			PBS_BLANK, PBS_RUN: begin
				if (state_r == PBS_BLANK) begin
					// kill level not acted on until the window closes
					if (blank_r >= CNT_W'(BLANK_P - 1)) begin
						state_nxt = power_kill_n_in ? PBS_RUN : PBS_OFF;
					end else begin
						blank_nxt = blank_r + 1'b1;
					end
				end else if (!power_kill_n_in) begin
					state_nxt = PBS_OFF;
				end
				// first input to go low owns the sequence
				if (src_r == PBS_SRC_NONE || !own_low) begin
					// the turn-on press itself must not count as a turn-off request
					if (src_r != PBS_SRC_BTN && req.btn_low && !need_rel_r && !(src_r == PBS_SRC_SUP && req.sup_low)) begin
						src_nxt = PBS_SRC_BTN;
					end else if (req.sup_low && !(src_r == PBS_SRC_BTN && req.btn_low)) begin
						src_nxt = PBS_SRC_SUP;
					end else if (!own_low) begin
						src_nxt = PBS_SRC_NONE;
					end
				end
				if (own_low && own_cnt >= CNT_W'(OFF_DB_P - 1) && !int_on_r) begin
					int_on_nxt  = 1'b1;
					int_cnt_nxt = '0;
				end else if (int_on_r) begin
					if (int_cnt_r < CNT_W'(INT_MIN_P)) begin
						int_cnt_nxt = int_cnt_r + 1'b1;
					end else if (!req.btn_low && !own_low) begin
						int_on_nxt = 1'b0;
					end
				end
				if (force_off) begin
					state_nxt = PBS_OFF;
				end
				if (state_nxt == PBS_OFF) begin
					int_on_nxt   = 1'b0;
					// a button still held across turn-off must be released first
					need_rel_nxt = req.btn_low;
				end
			end
			default: begin
				state_nxt = PBS_OFF;
			end
		endcase
		en_out_nxt  = (state_nxt != PBS_OFF) ? EN_ACTIVE_HIGH : !EN_ACTIVE_HIGH;
		int_out_nxt = !int_on_nxt;
	end

	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_r          <= PBS_OFF;
			src_r            <= PBS_SRC_NONE;
			blank_r          <= '0;
			int_cnt_r        <= '0;
			int_on_r         <= 1'b0;
			need_rel_r       <= 1'b0;
			power_enable_out <= !EN_ACTIVE_HIGH;
			interrupt_n_out  <= 1'b1;
		end else begin
			state_r          <= state_nxt;
			src_r            <= src_nxt;
			blank_r          <= blank_nxt;
			int_cnt_r        <= int_cnt_nxt;
			int_on_r         <= int_on_nxt;
			need_rel_r       <= need_rel_nxt;
			power_enable_out <= en_out_nxt;
			interrupt_n_out  <= int_out_nxt;
		end
	end

	on_needs_press_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
		(state_r == PBS_OFF && state_nxt != PBS_OFF) |-> (req.btn_low && btn_cnt >= CNT_W'(ON_DB_P - 1)))
		else $error("power on without full press");
	on_button_only_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
		$rose(state_r == PBS_BLANK) |-> $past(req.btn_low))
		else $error("power on without button");
	lockout_low_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
		(state_r == PBS_OFF && req.sup_low) |=> state_r == PBS_OFF)
		else $error("turn-on during supply lockout");
	blank_ignore_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
		(state_r == PBS_BLANK && blank_r < CNT_W'(BLANK_P - 1) && !force_off) |=> state_r != PBS_OFF)
		else $error("kill acted upon during blanking");
	blank_abort_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
		(state_r == PBS_BLANK && blank_r >= CNT_W'(BLANK_P - 1) && !power_kill_n_in) |=> state_r == PBS_OFF)
		else $error("kill low at blank end did not abort");
	kill_off_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
		(state_r == PBS_RUN && !power_kill_n_in) |=> power_enable_out != EN_ACTIVE_HIGH)
		else $error("kill did not release enable");
	int_raise_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
		(powered && own_low && own_cnt >= CNT_W'(OFF_DB_P - 1) && !force_off && state_nxt != PBS_OFF)
		|=> !interrupt_n_out) else $error("interrupt not raised");
	int_min_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
		($fell(interrupt_n_out) && int_cnt_r == '0) |-> (!interrupt_n_out || state_r == PBS_OFF)
		until_with (int_cnt_r >= CNT_W'(INT_MIN_P) || state_r == PBS_OFF))
		else $error("interrupt shorter than minimum");
	force_both_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
		(powered && force_off) |=> (interrupt_n_out && power_enable_out != EN_ACTIVE_HIGH))
		else $error("forced off did not release both");
	en_tracks_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
		(power_enable_out == EN_ACTIVE_HIGH) == powered)
		else $error("enable level disagrees with state");
	src_hold_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
		(powered && src_r == PBS_SRC_BTN && req.btn_low && state_nxt != PBS_OFF) |=> src_r == PBS_SRC_BTN)
		else $error("owner changed while held");
	fresh_press_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
		(state_r == PBS_OFF && need_rel_r) |=> state_r == PBS_OFF)
		else $error("re-enabled without fresh press");
endmodule
`default_nettype wire

/* File: pbs_pkg.sv */
/*
 * pbs_pkg: constants and carrier types for the push-button power sequencer.
 * assumes a 200 MHz system clock; times below are given in milliseconds and converted to cycles.
 */
`default_nettype none
package pbs_pkg;
	localparam int unsigned CLK_HZ         = 200_000_000;
	localparam int unsigned ON_DB_MS       = 32;   // turn_on_debounce_time
	localparam int unsigned OFF_DB_MS      = 32;   // turn_off_debounce_time
	localparam int unsigned INT_MIN_MS     = 32;   // minimum interrupt width
	localparam int unsigned BLANK_MS       = 512;  // kill blanking window
	localparam int unsigned PD_MIN_MS      = 64;   // min_power_down_time
	localparam int unsigned PDT_DEF_MS     = 64;   // default extra hold, no capacitor
	localparam int unsigned RST_DLY_MS     = 200;  // supervisor reset delay
	localparam int unsigned CYC_PER_MS     = CLK_HZ / 1000;
	localparam int unsigned ON_DB_CYC      = ON_DB_MS * CYC_PER_MS;
	localparam int unsigned OFF_DB_CYC     = OFF_DB_MS * CYC_PER_MS;
	localparam int unsigned INT_MIN_CYC    = INT_MIN_MS * CYC_PER_MS;
	localparam int unsigned BLANK_CYC      = BLANK_MS * CYC_PER_MS;
	localparam int unsigned PD_MIN_CYC     = PD_MIN_MS * CYC_PER_MS;
	localparam int unsigned PDT_DEF_CYC    = PDT_DEF_MS * CYC_PER_MS;
	localparam int unsigned RST_DLY_CYC    = RST_DLY_MS * CYC_PER_MS;
	localparam int          CNT_W          = 32;
	localparam logic        EN_HIGH_DEF    = 1'b1;

	typedef enum logic [1:0] {
		PBS_OFF   = 2'b00,
		PBS_BLANK = 2'b01,
		PBS_RUN   = 2'b10
	} pbs_state_t;

	typedef enum logic [1:0] {
		PBS_SRC_NONE = 2'b00,
		PBS_SRC_BTN  = 2'b01,
		PBS_SRC_SUP  = 2'b10
	} pbs_src_t;

	// the two power-down inputs as active-high "held low" levels
	typedef struct packed {
		logic btn_low;
		logic sup_low;
	} pbs_req_t;
endpackage
`default_nettype wire

/* File: pbs_low_timer.sv */
/*
 * pbs_low_timer: counts cycles an input has been continuously active.
 * assumes the input is synchronous to sys_clk_in; count saturates at top.
 */
`timescale 1ns/1ps
`default_nettype none
module pbs_low_timer
	import pbs_pkg::*;
(
	input  wire logic             sys_clk_in,
	input  wire logic             reset_n_in,
	input  wire logic             active_in,
	output logic      [CNT_W-1:0] count_out
);
	logic [CNT_W-1:0] count_nxt;

	always_comb begin
		if (!active_in) begin
			count_nxt = '0;
		end else if (count_out != {CNT_W{1'b1}}) begin
			count_nxt = count_out + 1'b1;
		end else begin
			count_nxt = count_out;
		end
	end

	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			count_out <= '0;
		end else begin
			count_out <= count_nxt;
		end
	end
endmodule
`default_nettype wire

/* File: pbs_supervisor.sv */
/*
 * pbs_supervisor: supply reset and power-fail flag, independent of sequencing.
 * assumes comparator outputs arrive synchronous, high meaning "below threshold" except fail_above_in, high meaning above the rising level.
 */
`timescale 1ns/1ps
`default_nettype none
module pbs_supervisor
	import pbs_pkg::*;
(
	input  wire logic sys_clk_in,
	input  wire logic reset_n_in,
	input  wire logic supply_below_in,
	input  wire logic fail_below_in,
	input  wire logic fail_above_in,
	output logic      supervisor_reset_n_out,
	output logic      fail_warn_n_out
);
	logic [CNT_W-1:0] good_cnt_r;
	logic [CNT_W-1:0] good_cnt_nxt;
	logic             rst_nxt;
	logic             warn_nxt;

	always_comb begin
		good_cnt_nxt = good_cnt_r;
		rst_nxt      = supervisor_reset_n_out;
		warn_nxt     = fail_warn_n_out;
		if (supply_below_in) begin
			good_cnt_nxt = '0;
			rst_nxt      = 1'b0;
		end else if (good_cnt_r >= CNT_W'(RST_DLY_CYC - 1)) begin
			rst_nxt = 1'b1;
		end else begin
			good_cnt_nxt = good_cnt_r + 1'b1;
		end
		// hysteresis: low below falling level, released only above rising level
		if (fail_below_in) begin
			warn_nxt = 1'b0;
		end else if (fail_above_in) begin
			warn_nxt = 1'b1;
		end
	end

	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			good_cnt_r             <= '0;
			supervisor_reset_n_out <= 1'b0;
			fail_warn_n_out        <= 1'b1;
		end else begin
			good_cnt_r             <= good_cnt_nxt;
			supervisor_reset_n_out <= rst_nxt;
			fail_warn_n_out        <= warn_nxt;
		end
	end

	supply_low_rst_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
		supply_below_in |=> !supervisor_reset_n_out) else $error("reset not held while supply low");
	fail_warn_low_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
		fail_below_in |=> !fail_warn_n_out) else $error("fail warning not asserted");
	fail_warn_hold_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
		(!fail_below_in && !fail_above_in) |=> fail_warn_n_out == $past(fail_warn_n_out))
		else $error("fail warning moved inside hysteresis band");
endmodule
`default_nettype wire

/* File: pbs_host_model.sv */
/*
 * pbs_host_model: host processor side of the kill handshake.
 * assumes the host is powered only while the enable output is active.
 */
`timescale 1ns/1ps
`default_nettype none
module pbs_host_model #(
	parameter int unsigned DLY = 4
) (
	input  wire logic sys_clk_in,
	input  wire logic reset_n_in,
	input  wire logic power_on_in,
	input  wire logic interrupt_n_in,
	input  wire logic boot_ok_in,
	input  wire logic obey_in,
	output logic      power_kill_n_out
);
	int unsigned cnt_r;
	// an unpowered host cannot hold kill high
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			power_kill_n_out <= 1'b0;
			cnt_r            <= 0;
		end else if (!power_on_in) begin
			power_kill_n_out <= 1'b0;
			cnt_r            <= 0;
		end else if (cnt_r == DLY) begin
			power_kill_n_out <= !power_kill_n_out;
			cnt_r            <= 0;
		end else if (power_kill_n_out ? (!interrupt_n_in && obey_in) : boot_ok_in) begin
			cnt_r <= cnt_r + 1;
		end else begin
			cnt_r <= 0;
		end
	end
endmodule
`default_nettype wire

/* File: tb_top.sv */
/*
 * tb_top: self-checking bench for pbs_sequencer with shortened timers.
 * assumes the host model answers the kill handshake; no random stimulus.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import pbs_pkg::*;
	localparam int unsigned ONP = 8, OFFP = 8, INTP = 8, BLKP = 32, PDP = 16, PDTP = 16;
	logic             clk = 1'b0, rst_n = 1'b0, btn = 1'b1, sup_low = 1'b0, cap = 1'b0;
	logic [CNT_W-1:0] extra = '0;
	logic             f_below = 1'b0, f_above = 1'b1, mon_low = 1'b0, boot_ok = 1'b1, obey = 1'b0;
	logic             kill_n, en, int_n, warn_n, sres_n;
	int               error_cnt = 0, total_checks = 0;

	pbs_sequencer #(.ON_DB_P(ONP), .OFF_DB_P(OFFP), .INT_MIN_P(INTP), .BLANK_P(BLKP),
		.PD_MIN_P(PDP), .PDT_DEF_P(PDTP)) u_dut (
		.sys_clk_in(clk), .reset_n_in(rst_n), .push_button_n_in(btn), .supply_low_in(sup_low),
		.power_kill_n_in(kill_n), .hold_delay_cap_in(cap), .extra_hold_cyc_in(extra),
		.fail_below_in(f_below), .fail_above_in(f_above), .monitored_supply_low_in(mon_low),
		.power_enable_out(en), .interrupt_n_out(int_n), .fail_warn_n_out(warn_n),
		.supervisor_reset_n_out(sres_n));
	pbs_host_model u_host (.sys_clk_in(clk), .reset_n_in(rst_n), .power_on_in(en),
		.interrupt_n_in(int_n), .boot_ok_in(boot_ok), .obey_in(obey), .power_kill_n_out(kill_n));

	always #2.5 clk = ~clk;

	task automatic chk(input logic got, input logic exp, input string m);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t %s", $time, m);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	// wait for enable (sel 0) or interrupt (sel 1) to reach v, bounded
	task automatic wt(input bit sel, input logic v, input int max, input string m);
		int i;
		i = 0;
		while ((sel ? int_n : en) !== v && i < max) begin
			@(negedge clk);
			i++;
		end
		chk(sel ? int_n : en, v, m);
	endtask
	task automatic press(input int n);
		@(posedge clk);
		btn <= 1'b0;
		repeat (n) @(posedge clk);
		btn <= 1'b1;
		@(negedge clk);
	endtask
	task automatic power_on();
		boot_ok <= 1'b1;
		press(ONP + 2);
		wt(0, 1'b1, 4, "no power on");
		cyc(BLKP + 8);
		chk(en, 1'b1, "power lost after blanking");
	endtask

	task automatic t_short_press();
		press(ONP - 2);
		cyc(6);
		chk(en, 1'b0, "short press powered on");
	endtask
	task automatic t_abort();
		boot_ok <= 1'b0;
		press(ONP + 2);
		wt(0, 1'b1, 4, "no power on");
		cyc(BLKP - 4);
		chk(en, 1'b1, "kill acted on inside blanking");
		wt(0, 1'b0, 10, "no abort at blanking end");
		boot_ok <= 1'b1;
	endtask
	task automatic t_int_kill();
		power_on();
		obey <= 1'b0;
		press(OFFP + 2);
		wt(1, 1'b0, 4, "no interrupt");
		cyc(INTP / 2);
		chk(int_n, 1'b0, "interrupt too short");
		chk(en, 1'b1, "short press removed power");
		wt(1, 1'b1, INTP + 4, "interrupt stuck");
		obey <= 1'b1;
		press(OFFP + 2);
		wt(0, 1'b0, 12, "kill ignored");
		chk(int_n, 1'b1, "interrupt left after off");
		obey <= 1'b0;
	endtask
	task automatic t_force(input logic c, input int ex);
		int lim;
		lim = PDP + (c ? ex : PDTP);
		cap <= c;
		extra <= CNT_W'(ex);
		power_on();
		@(posedge clk);
		btn <= 1'b0;
		cyc(lim - 3);
		chk(int_n, 1'b0, "no interrupt while held");
		chk(en, 1'b1, "forced off too early");
		wt(0, 1'b0, 6, "no forced off");
		chk(int_n, 1'b1, "interrupt not released with enable");
		cyc(ONP + 4);
		chk(en, 1'b0, "held button restarted power");
		@(posedge clk);
		btn <= 1'b1;
		cyc(2);
	endtask
	task automatic t_lockout();
		@(posedge clk);
		sup_low <= 1'b1;
		press(ONP + 4);
		cyc(4);
		chk(en, 1'b0, "locked-out press powered on");
		@(posedge clk);
		sup_low <= 1'b0;
		cyc(2);
	endtask
	task automatic t_supply_int();
		power_on();
		@(posedge clk);
		sup_low <= 1'b1;
		cyc(OFFP + 3);
		chk(int_n, 1'b0, "supply low raised no interrupt");
		@(posedge clk);
		sup_low <= 1'b0;
		obey <= 1'b1;
		wt(0, 1'b0, 12, "kill ignored");
		obey <= 1'b0;
	endtask
	task automatic t_monitors();
		@(posedge clk);
		f_below <= 1'b1;
		f_above <= 1'b0;
		mon_low <= 1'b1;
		cyc(2);
		chk(warn_n, 1'b0, "no fail warning");
		chk(sres_n, 1'b0, "no supervisor reset");
		@(posedge clk);
		f_below <= 1'b0;
		mon_low <= 1'b0;
		cyc(100);
		chk(warn_n, 1'b0, "warning lost in hysteresis band");
		chk(sres_n, 1'b1 ^ 1'b1, "reset released before delay");
		@(posedge clk);
		f_above <= 1'b1;
		cyc(2);
		chk(warn_n, 1'b1, "warning not released");
	endtask

	task automatic conclude();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// the whole sequence needs well under 2000 cycles
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		conclude();
	end
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		cyc(2);
		chk(en, 1'b0, "enable active after reset");
		chk(int_n, 1'b1, "interrupt after reset");
		chk(warn_n, 1'b1, "warning after reset");
		t_short_press();
		t_abort();
		t_int_kill();
		t_force(1'b0, 0);
		t_force(1'b1, 4);
		t_lockout();
		t_supply_int();
		t_monitors();
		conclude();
	end
endmodule
`default_nettype wire
